// File: hdl/rta_alarm.sv
// alarm comparison, flags and shared open-drain interrupt of the clock
// assumes a register port already decoded from the serial link and a
// minute tick from the crystal prescaler, both synchronous to clk
`timescale 1ns/1ps

// How it works
// - enabled minute, hour, weekday-or-date fields equal the time: alarm event.
// - writing the present time raises nothing until counters next advance.
// - an alarm event sets the alarm flag; it stays set until cleared.
// - writing one to the alarm flag does nothing; writing zero clears it.
// - event with alarm interrupt enable set pulls the interrupt line low.
// - line stays low until alarm flag or enable is cleared.
// - clearing the enable releases the line at once, flag stays set.
// - clearing the alarm flag releases the line at once.
// - event with enable clear sets the flag, line stays released.
// - line is the wired combination of alarm and timer sources.
// - no alarm events while stop or counter reset hold is set.
// - select bit picks weekday mask (zero) or date (one) comparison.
// - weekday mode: seven low bits are days, any set day matches.
// - bit 7 of an alarm register removes that field from comparison.
// - all three fields disabled: alarm event every minute.
// - alarm registers are plain read/write storage; keep enable off then.
module rta_alarm (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire rta_pkg::rta_req_s req,
  output logic [7:0]             rdata,
  output logic                   rvalid,
  input  wire logic              minute_tick,
  input  wire logic              timer_event,
  input  wire logic              low_voltage_event,
  input  wire logic              counter_reset_hold,
  input  wire logic              irq_n_in,
  output logic                   irq_n_out,
  output logic                   irq_oe_n,
  output logic                   timer_run_enable,
  output logic                   timer_src_sel_hi,
  output logic                   timer_src_sel_lo,
  output logic                   clkout_freq_sel_hi,
  output logic                   clkout_freq_sel_lo
);

  logic [7:0]                 alarm_minute;
  logic [7:0]                 alarm_hour;
  logic [7:0]                 alarm_date_or_weekday;
  logic [7:0]                 extension_control;
  logic [7:0]                 interrupt_control;
  logic                       alarm_event_flag;
  logic                       timer_event_flag;
  logic                       low_voltage_flag;
  rta_pkg::rta_time_s         now;
  logic                       advanced;
  logic                       run;
  logic                       weekday_or_date_select;
  logic                       alarm_irq_enable;
  logic                       timer_irq_enable;
  logic                       stop_bit;
  logic                       wr_flag;
  logic                       wr_ctrl;
  logic                       wr_ext;
  logic [rta_pkg::WDAY_W-1:0] day_hits;
  logic                       min_ok;
  logic                       hour_ok;
  logic                       day_ok;
  logic                       alarm_event;
  logic                       alarm_drive;
  logic                       timer_drive;
  logic [7:0]                 next_rdata;

  assign wr_flag = req.wr && (req.addr == rta_pkg::IDX_FLAG);
  assign wr_ctrl = req.wr && (req.addr == rta_pkg::IDX_CTRL);
  assign wr_ext  = req.wr && (req.addr == rta_pkg::IDX_EXT);

  assign weekday_or_date_select = extension_control[rta_pkg::BIT_WEEKDAY_OR_DATE_SELECT];
  assign alarm_irq_enable       = interrupt_control[rta_pkg::BIT_AIE];
  assign timer_irq_enable       = interrupt_control[rta_pkg::BIT_TIE];
  assign stop_bit               = interrupt_control[rta_pkg::BIT_STOP];
  assign timer_run_enable       = extension_control[rta_pkg::BIT_TE];
  assign timer_src_sel_hi       = extension_control[rta_pkg::BIT_TSEL_HI];
  assign timer_src_sel_lo       = extension_control[rta_pkg::BIT_TSEL_LO];
  assign clkout_freq_sel_hi     = extension_control[rta_pkg::BIT_FSEL_HI];
  assign clkout_freq_sel_lo     = extension_control[rta_pkg::BIT_FSEL_LO];

  assign run = !stop_bit && !counter_reset_hold;

  rta_time_counter u_time (
    .clk         (clk),
    .srst        (srst),
    .minute_tick (minute_tick),
    .run         (run),
    .req         (req),
    .now         (now),
    .advanced    (advanced)
  );

  for (genvar i = 0; i < rta_pkg::WDAY_W; i++) begin : g_wday
    assign day_hits[i] = alarm_date_or_weekday[i] & now.weekday[i];
  end

  assign min_ok  = alarm_minute[rta_pkg::BIT_FIELD_DIS] ||
                   ((alarm_minute & rta_pkg::MASK_MIN) ==
                    (now.minute & rta_pkg::MASK_MIN));
  assign hour_ok = alarm_hour[rta_pkg::BIT_FIELD_DIS] ||
                   ((alarm_hour & rta_pkg::MASK_HOUR) ==
                    (now.hour & rta_pkg::MASK_HOUR));
  assign day_ok  = alarm_date_or_weekday[rta_pkg::BIT_FIELD_DIS] ||
                   (weekday_or_date_select ?
                    ((alarm_date_or_weekday & rta_pkg::MASK_DATE) ==
                     (now.date & rta_pkg::MASK_DATE)) :
                    (|day_hits));

  assign alarm_event = advanced && run && min_ok && hour_ok && day_ok;

  always_ff @(posedge clk) begin
    if (srst) begin
      alarm_minute          <= rta_pkg::RST_REG;
      alarm_hour            <= rta_pkg::RST_REG;
      alarm_date_or_weekday <= rta_pkg::RST_REG;
    end else if (req.wr) begin
      if (req.addr == rta_pkg::IDX_ALM_MIN) begin
        alarm_minute <= req.wdata;
      end
      if (req.addr == rta_pkg::IDX_ALM_HOUR) begin
        alarm_hour <= req.wdata;
      end
      if (req.addr == rta_pkg::IDX_ALM_DAY) begin
        alarm_date_or_weekday <= req.wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      extension_control <= rta_pkg::RST_REG;
    end else if (wr_ext) begin
      extension_control <= req.wdata & rta_pkg::MASK_EXT;
    end
  end

  // enable is only ever changed by software
  always_ff @(posedge clk) begin
    if (srst) begin
      interrupt_control <= rta_pkg::RST_REG;
    end else if (wr_ctrl) begin
      interrupt_control <= req.wdata & rta_pkg::MASK_CTRL;
    end
  end

  // only zero clears
  // set beats a clear in the same cycle so no event is lost
  always_ff @(posedge clk) begin
    if (srst) begin
      alarm_event_flag <= 1'b0;
    end else if (alarm_event) begin
      alarm_event_flag <= 1'b1;
    end else if (wr_flag && !req.wdata[rta_pkg::BIT_AF]) begin
      alarm_event_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      timer_event_flag <= 1'b0;
    end else if (timer_event) begin
      timer_event_flag <= 1'b1;
    end else if (wr_flag && !req.wdata[rta_pkg::BIT_TF]) begin
      timer_event_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      low_voltage_flag <= 1'b0;
    end else if (low_voltage_event) begin
      low_voltage_flag <= 1'b1;
    end else if (wr_flag && !req.wdata[rta_pkg::BIT_VLF]) begin
      low_voltage_flag <= 1'b0;
    end
  end

  assign alarm_drive = alarm_event_flag && alarm_irq_enable;
  // timer source simplified to flag and enable; its clear rules live outside
  assign timer_drive = timer_event_flag && timer_irq_enable;
  // wired sources
  // gated from flops, not registered, so release is immediate
  assign irq_oe_n  = !(alarm_drive || timer_drive);
  assign irq_n_out = 1'b0;

  always_comb begin
    next_rdata = rta_pkg::RST_REG;
    case (req.addr)
      rta_pkg::IDX_CUR_MIN:  next_rdata = now.minute;
      rta_pkg::IDX_CUR_HOUR: next_rdata = now.hour;
      rta_pkg::IDX_CUR_WDAY: next_rdata = now.weekday;
      rta_pkg::IDX_CUR_DATE: next_rdata = now.date;
      rta_pkg::IDX_ALM_MIN:  next_rdata = alarm_minute;
      rta_pkg::IDX_ALM_HOUR: next_rdata = alarm_hour;
      rta_pkg::IDX_ALM_DAY:  next_rdata = alarm_date_or_weekday;
      rta_pkg::IDX_EXT:      next_rdata = extension_control;
      rta_pkg::IDX_FLAG: begin
        next_rdata[rta_pkg::BIT_TF]  = timer_event_flag;
        next_rdata[rta_pkg::BIT_AF]  = alarm_event_flag;
        next_rdata[rta_pkg::BIT_VLF] = low_voltage_flag;
      end
      rta_pkg::IDX_CTRL:     next_rdata = interrupt_control;
      default:               next_rdata = rta_pkg::RST_REG;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata  <= rta_pkg::RST_REG;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      if (req.rd) begin
        rdata <= next_rdata;
      end
    end
  end

  // line level is observed by the host, not needed inside
  logic unused_line;
  assign unused_line = irq_n_in;

  sequence s_alarm_fires;
    alarm_event && alarm_irq_enable;
  endsequence

  sequence s_quiet_timer;
    !timer_drive;
  endsequence

  set_flag_a: assert property (
    @(posedge clk) disable iff (srst)
    alarm_event |=> alarm_event_flag)
    else $error("alarm flag not set after event");

  hold_flag_a: assert property (
    @(posedge clk) disable iff (srst)
    alarm_event_flag && !(wr_flag && !req.wdata[rta_pkg::BIT_AF])
    |=> alarm_event_flag)
    else $error("alarm flag dropped without a zero write");

  one_write_a: assert property (
    @(posedge clk) disable iff (srst)
    !alarm_event_flag && !alarm_event && wr_flag
    |=> !alarm_event_flag)
    else $error("writing one set the alarm flag");

  irq_low_a: assert property (
    @(posedge clk) disable iff (srst)
    s_alarm_fires ##1 (alarm_event_flag && alarm_irq_enable)[*2]
    |-> !irq_oe_n)
    else $error("interrupt line not driven after enabled alarm");

  aie_release_a: assert property (
    @(posedge clk) disable iff (srst)
    $fell(alarm_irq_enable) && alarm_event_flag ##0 s_quiet_timer
    |-> irq_oe_n)
    else $error("line held after alarm enable cleared");

  af_release_a: assert property (
    @(posedge clk) disable iff (srst)
    $fell(alarm_event_flag) && $past(alarm_irq_enable) ##0 s_quiet_timer
    |-> irq_oe_n)
    else $error("line held after alarm flag cleared");

  no_enable_a: assert property (
    @(posedge clk) disable iff (srst)
    alarm_event && !alarm_irq_enable ##1 !alarm_irq_enable ##0 s_quiet_timer
    |-> irq_oe_n && alarm_event_flag)
    else $error("line driven while alarm enable clear");

  timer_wire_a: assert property (
    @(posedge clk) disable iff (srst)
    timer_drive && !alarm_irq_enable |-> !irq_oe_n)
    else $error("timer source not seen on shared line");

  stop_block_a: assert property (
    @(posedge clk) disable iff (srst)
    stop_bit || counter_reset_hold |-> !alarm_event)
    else $error("alarm event while stopped");

  advance_only_a: assert property (
    @(posedge clk) disable iff (srst)
    alarm_event |-> $past(minute_tick) && advanced)
    else $error("alarm event without a minute update");

  every_minute_a: assert property (
    @(posedge clk) disable iff (srst)
    advanced && run && alarm_minute[rta_pkg::BIT_FIELD_DIS] &&
    alarm_hour[rta_pkg::BIT_FIELD_DIS] &&
    alarm_date_or_weekday[rta_pkg::BIT_FIELD_DIS] |-> alarm_event)
    else $error("all fields disabled yet no event");

  wday_mask_a: assert property (
    @(posedge clk) disable iff (srst)
    advanced && run && !weekday_or_date_select &&
    (alarm_minute[rta_pkg::BIT_FIELD_DIS] || (alarm_minute == now.minute)) &&
    alarm_hour[rta_pkg::BIT_FIELD_DIS] &&
    ((alarm_date_or_weekday & now.weekday & rta_pkg::MASK_WDAY) != 8'h00)
    |-> alarm_event)
    else $error("set weekday missed");

  date_miss_a: assert property (
    @(posedge clk) disable iff (srst)
    weekday_or_date_select &&
    !alarm_date_or_weekday[rta_pkg::BIT_FIELD_DIS] &&
    ((alarm_date_or_weekday & rta_pkg::MASK_DATE) != now.date)
    |-> !alarm_event)
    else $error("event on wrong date");

  bcd_min_a: assert property (
    @(posedge clk) disable iff (srst)
    advanced && run && (alarm_minute == now.minute) &&
    (alarm_hour[rta_pkg::BIT_FIELD_DIS] || (alarm_hour == now.hour)) &&
    alarm_date_or_weekday[rta_pkg::BIT_FIELD_DIS] |-> alarm_event)
    else $error("equal bcd minute did not match");

endmodule // rta_alarm

// File: hdl/rta_pkg.sv
// constants, field layouts and carriers shared by the alarm block
// assumes registers are reached by a 4-bit index and 8-bit data port
package rta_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int WDAY_W = 7;

  // register indices
  localparam logic [ADDR_W-1:0] IDX_CUR_MIN  = 4'h1;
  localparam logic [ADDR_W-1:0] IDX_CUR_HOUR = 4'h2;
  localparam logic [ADDR_W-1:0] IDX_CUR_WDAY = 4'h3;
  localparam logic [ADDR_W-1:0] IDX_CUR_DATE = 4'h4;
  localparam logic [ADDR_W-1:0] IDX_ALM_MIN  = 4'h8;
  localparam logic [ADDR_W-1:0] IDX_ALM_HOUR = 4'h9;
  localparam logic [ADDR_W-1:0] IDX_ALM_DAY  = 4'hA;
  localparam logic [ADDR_W-1:0] IDX_EXT      = 4'hD;
  localparam logic [ADDR_W-1:0] IDX_FLAG     = 4'hE;
  localparam logic [ADDR_W-1:0] IDX_CTRL     = 4'hF;

  // bit positions
  localparam int BIT_FIELD_DIS = 7;
  localparam int BIT_WEEKDAY_OR_DATE_SELECT      = 6;
  localparam int BIT_TE        = 4;
  localparam int BIT_FSEL_HI   = 3;
  localparam int BIT_FSEL_LO   = 2;
  localparam int BIT_TSEL_HI   = 1;
  localparam int BIT_TSEL_LO   = 0;
  localparam int BIT_TF        = 4;
  localparam int BIT_AF        = 3;
  localparam int BIT_VLF       = 1;
  localparam int BIT_TIE       = 4;
  localparam int BIT_AIE       = 3;
  localparam int BIT_STOP      = 1;

  // writable or compared bits per register
  localparam logic [DATA_W-1:0] MASK_MIN  = 8'h7F;
  localparam logic [DATA_W-1:0] MASK_HOUR = 8'h3F;
  localparam logic [DATA_W-1:0] MASK_WDAY = 8'h7F;
  localparam logic [DATA_W-1:0] MASK_DATE = 8'h3F;
  localparam logic [DATA_W-1:0] MASK_EXT  = 8'h5F;
  localparam logic [DATA_W-1:0] MASK_CTRL = 8'h1A;

  // reset values and counting limits, packed bcd
  localparam logic [DATA_W-1:0] RST_REG      = 8'h00;
  localparam logic [DATA_W-1:0] RST_WDAY     = 8'h01;
  localparam logic [DATA_W-1:0] BCD_MIN_MAX  = 8'h59;
  localparam logic [DATA_W-1:0] BCD_HOUR_MAX = 8'h23;
  localparam logic [DATA_W-1:0] BCD_DATE_MAX = 8'h31;
  localparam logic [DATA_W-1:0] BCD_DATE_1ST = 8'h01;
  localparam logic [3:0]        BCD_DIG_MAX  = 4'h9;

  typedef struct packed {
    logic [DATA_W-1:0] minute;
    logic [DATA_W-1:0] hour;
    logic [DATA_W-1:0] weekday;
    logic [DATA_W-1:0] date;
  } rta_time_s;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } rta_req_s;

endpackage

// File: hdl/rta_time_counter.sv
// minute, hour and date counters in packed bcd, weekday as a rotating seven-bit one-hot mask
// assumes one minute_tick pulse per minute from the crystal prescaler
`timescale 1ns/1ps
module rta_time_counter (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              minute_tick,
  input  wire logic              run,
  input  wire rta_pkg::rta_req_s req,
  output rta_pkg::rta_time_s     now,
  output logic                   advanced
);

  logic wr_time;
  logic tick_taken;
  logic min_wrap;
  logic hour_wrap;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == rta_pkg::BCD_DIG_MAX) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  assign wr_time    = req.wr && ((req.addr == rta_pkg::IDX_CUR_MIN) ||
                      (req.addr == rta_pkg::IDX_CUR_HOUR) ||
                      (req.addr == rta_pkg::IDX_CUR_WDAY) ||
                      (req.addr == rta_pkg::IDX_CUR_DATE));
  // a software write wins over a tick in the same cycle
  assign tick_taken = minute_tick && run && !wr_time;
  assign min_wrap   = (now.minute == rta_pkg::BCD_MIN_MAX);
  assign hour_wrap  = min_wrap && (now.hour == rta_pkg::BCD_HOUR_MAX);

  always_ff @(posedge clk) begin
    if (srst) begin
      now.minute  <= rta_pkg::RST_REG;
      now.hour    <= rta_pkg::RST_REG;
      now.weekday <= rta_pkg::RST_WDAY;
      now.date    <= rta_pkg::BCD_DATE_1ST;
    end else if (wr_time) begin
      case (req.addr)
        rta_pkg::IDX_CUR_MIN:  now.minute  <= req.wdata & rta_pkg::MASK_MIN;
        rta_pkg::IDX_CUR_HOUR: now.hour    <= req.wdata & rta_pkg::MASK_HOUR;
        rta_pkg::IDX_CUR_WDAY: now.weekday <= req.wdata & rta_pkg::MASK_WDAY;
        default:               now.date    <= req.wdata & rta_pkg::MASK_DATE;
      endcase
    end else if (tick_taken) begin
      now.minute <= min_wrap ? rta_pkg::RST_REG : bcd_inc(now.minute);
      if (min_wrap) begin
        now.hour <= hour_wrap ? rta_pkg::RST_REG : bcd_inc(now.hour);
      end
      // no month counter here: date wraps after the 31st
      if (hour_wrap) begin
        now.weekday <= {1'b0, now.weekday[5:0], now.weekday[6]};
        now.date    <= (now.date == rta_pkg::BCD_DATE_MAX) ?
                       rta_pkg::BCD_DATE_1ST : bcd_inc(now.date);
      end
    end
  end

  // marks the cycle in which the new time is visible
  always_ff @(posedge clk) begin
    if (srst) begin
      advanced <= 1'b0;
    end else begin
      advanced <= tick_taken;
    end
  end

endmodule // rta_time_counter

// File: sim/rta_host_model.sv
// host side of the shared open-drain interrupt line
// assumes the block pulls the line only through its active-low enable
`timescale 1ns/1ps
module rta_host_model (
  input  wire logic irq_n_out,
  input  wire logic irq_oe_n,
  output logic      irq_line
);
  // wired line level
  // released line rises to the pull-up, never keeps the last value
  assign irq_line = irq_oe_n ? 1'b1 : irq_n_out;
endmodule // rta_host_model

// File: sim/test_rta_alarm.sv
// self-checking bench for the alarm block and its register port
// assumes the host model resolves the open-drain interrupt line
`timescale 1ns/1ps
module test_rta_alarm;
  logic              clk = 1'b0;
  logic              srst = 1'b1;
  rta_pkg::rta_req_s req = '0;
  logic              minute_tick = 1'b0;
  logic              timer_event = 1'b0;
  logic              low_voltage_event = 1'b0;
  logic              counter_reset_hold = 1'b0;
  logic [7:0]        rdata;
  logic              rvalid;
  logic              irq_n_out;
  logic              irq_oe_n;
  logic              irq_line;
  logic [4:0]        ext_pins;
  logic [7:0]        exp_q[$];
  logic [7:0]        rnd;
  int                num_errors = 0;
  int                samples_checked = 0;
  int                cycles = 0;
  // match cases
  // columns: alarm min, hour, day, ext, ctrl, hold, event expected
  logic [55:0]       tbl [11] = '{
    56'h10_00_80_00_08_00_01, 56'h11_00_80_00_08_00_00,
    56'h10_01_80_00_08_00_00, 56'h80_80_80_00_08_00_01,
    56'h10_80_05_00_08_00_01, 56'h10_80_02_00_08_00_00,
    56'h10_80_01_40_08_00_01, 56'h10_80_02_40_08_00_00,
    56'h10_00_80_00_00_00_01, 56'h10_00_80_00_0A_00_00,
    56'h10_00_80_00_08_01_00};

  always #2 clk = ~clk;

  rta_alarm rta_alarm_i (
    .clk                (clk),
    .srst               (srst),
    .req                (req),
    .rdata              (rdata),
    .rvalid             (rvalid),
    .minute_tick        (minute_tick),
    .timer_event        (timer_event),
    .low_voltage_event  (low_voltage_event),
    .counter_reset_hold (counter_reset_hold),
    .irq_n_in           (irq_line),
    .irq_n_out          (irq_n_out),
    .irq_oe_n           (irq_oe_n),
    .timer_run_enable   (ext_pins[4]),
    .timer_src_sel_hi   (ext_pins[1]),
    .timer_src_sel_lo   (ext_pins[0]),
    .clkout_freq_sel_hi (ext_pins[3]),
    .clkout_freq_sel_lo (ext_pins[2])
  );

  rta_host_model rta_host_model_i (
    .irq_n_out (irq_n_out),
    .irq_oe_n  (irq_oe_n),
    .irq_line  (irq_line)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // each access waits its own edge so strobes never toggle twice a step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk);
    req.wr = 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(negedge clk);
    req.rd = 1'b1;
    req.addr = a;
    exp_q.push_back(e);
    @(negedge clk);
    req.rd = 1'b0;
  endtask

  task automatic tick;
    @(negedge clk);
    minute_tick = 1'b1;
    @(negedge clk);
    minute_tick = 1'b0;
  endtask

  task automatic chk_irq(input logic e);
    check({7'h00, irq_line}, {7'h00, e});
  endtask

  task automatic trial(input logic [55:0] r);
    wr(rta_pkg::IDX_CTRL, 8'h00);
    wr(rta_pkg::IDX_ALM_MIN, r[55:48]);
    wr(rta_pkg::IDX_ALM_HOUR, r[47:40]);
    wr(rta_pkg::IDX_ALM_DAY, r[39:32]);
    wr(rta_pkg::IDX_EXT, r[31:24]);
    wr(rta_pkg::IDX_CUR_MIN, 8'h09);
    wr(rta_pkg::IDX_CTRL, r[23:16]);
    counter_reset_hold = r[8];
    tick();
    counter_reset_hold = 1'b0;
    idle(3);
    rd(rta_pkg::IDX_FLAG, {4'h0, r[0], 3'h0});
    chk_irq(~(r[0] & r[19]));
    rd(rta_pkg::IDX_CUR_MIN, (r[17] | r[8]) ? 8'h09 : 8'h10);
  endtask

  // oldest pending read expectation meets each read result
  always @(negedge clk) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("mismatch at %0t: unexpected read data", $time);
      end else begin
        check(rdata, exp_q.pop_front());
      end
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    void'($urandom(41278));
    repeat (5) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    rd(rta_pkg::IDX_CUR_WDAY, rta_pkg::RST_WDAY);
    rd(rta_pkg::IDX_CUR_DATE, rta_pkg::BCD_DATE_1ST);
    rd(rta_pkg::IDX_FLAG, 8'h00);
    chk_irq(1'b1);
    wr(4'h5, 8'hFF);
    rd(4'h5, 8'h00);
    wr(rta_pkg::IDX_EXT, 8'hFF);
    rd(rta_pkg::IDX_EXT, rta_pkg::MASK_EXT);
    wr(rta_pkg::IDX_CTRL, 8'hFF);
    rd(rta_pkg::IDX_CTRL, rta_pkg::MASK_CTRL);
    wr(rta_pkg::IDX_CTRL, 8'h00);
    for (int a = 8; a < 11; a++) begin
      rnd = 8'($urandom);
      wr(a[3:0], rnd);
      rd(a[3:0], rnd);
    end
    // extension bits must reach their output pins
    rnd = 8'($urandom);
    wr(rta_pkg::IDX_EXT, rnd);
    check({3'h0, ext_pins}, {3'h0, rnd[4:0]});
    wr(rta_pkg::IDX_ALM_MIN, 8'h10);
    wr(rta_pkg::IDX_ALM_HOUR, 8'h00);
    wr(rta_pkg::IDX_ALM_DAY, 8'h80);
    wr(rta_pkg::IDX_CUR_MIN, 8'h10);
    wr(rta_pkg::IDX_CTRL, 8'h08);
    idle(5);
    rd(rta_pkg::IDX_FLAG, 8'h00);
    chk_irq(1'b1);
    for (int i = 0; i < 11; i++) begin
      trial(tbl[i]);
      if (i == 0) begin
        wr(rta_pkg::IDX_FLAG, 8'hFF);
        rd(rta_pkg::IDX_FLAG, 8'h08);
        chk_irq(1'b0);
        wr(rta_pkg::IDX_CTRL, 8'h00);
        chk_irq(1'b1);
        rd(rta_pkg::IDX_FLAG, 8'h08);
        wr(rta_pkg::IDX_CTRL, 8'h08);
        chk_irq(1'b0);
      end
      wr(rta_pkg::IDX_FLAG, 8'h00);
      chk_irq(1'b1);
      idle(4);
      rd(rta_pkg::IDX_FLAG, 8'h00);
    end
    wr(rta_pkg::IDX_CTRL, 8'h10);
    @(negedge clk);
    timer_event = 1'b1;
    low_voltage_event = 1'b1;
    @(negedge clk);
    timer_event = 1'b0;
    low_voltage_event = 1'b0;
    idle(2);
    chk_irq(1'b0);
    rd(rta_pkg::IDX_FLAG, 8'h12);
    wr(rta_pkg::IDX_FLAG, 8'h00);
    chk_irq(1'b1);
    // a one written to a clear flag must not set it
    wr(rta_pkg::IDX_FLAG, 8'hFF);
    rd(rta_pkg::IDX_FLAG, 8'h00);
    idle(3);
    if (exp_q.size() != 0) begin
      num_errors++;
    end
    end_of_test();
  end
endmodule // test_rta_alarm
